// >>> rtl/jtl_consts.svh
`ifndef JTL_CONSTS_SVH
`define JTL_CONSTS_SVH
// control characters, 8-bit values
`define JTL_K_R 8'h1c
`define JTL_K_A 8'h7c
`define JTL_K_Q 8'h9c
`define JTL_K_K 8'hbc
`define JTL_K_F 8'hfc
// 6b/4b codes at negative disparity for K28.y, both groups invert at positive
`define JTL_K28_6B_NEG 6'h0f
`define JTL_K28_R_4B_NEG 4'h4
`define JTL_K28_A_4B_NEG 4'h3
`define JTL_K28_Q_4B_NEG 4'h2
`define JTL_K28_K_4B_NEG 4'ha
`define JTL_K28_F_4B_NEG 4'h8
// scrambler seed and lfsr taps
`define JTL_SCR_SEED 15'h7f80
`define JTL_SCR_TAP_HI 14
`define JTL_SCR_TAP_LO 13
// number of alignment multiframes and configuration octets
`define JTL_ILAS_MF 3'h4
`define JTL_CFG_OCTETS 4'he
`define JTL_CFG_START 8'h02
// control register reset values
`define JTL_RST_SCR_EN 1'b1
`define JTL_RST_ALIGN_EN 1'b1
`define JTL_RST_TWOS 1'b1
`endif

// >>> rtl/jtl_pkg.sv
package jtl_pkg;
  typedef enum logic [1:0] {
    JTL_CGS,
    JTL_WAIT_LMFC,
    JTL_ILAS,
    JTL_DATA
  } jtl_state_t;
  typedef enum logic [1:0] {
    JTL_MODE_ONE = 2'h0,
    JTL_MODE_TWO = 2'h1,
    JTL_MODE_FOUR = 2'h2,
    JTL_MODE_ADC = 2'h3
  } jtl_mode_t;
  typedef struct packed {
    logic [15:0] i;
    logic [15:0] q;
  } jtl_iq_t;
  typedef struct packed {
    logic [9:0] sym;
    logic is_k;
    logic [7:0] octet;
  } jtl_sym_t;
endpackage

// >>> rtl/jtl_tx_link.sv
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "jtl_consts.svh"
// Contract
// - after sync release, alignment sequence starts at next multiframe boundary
// - alignment runs four multiframes, each opening /R/ and closing /A/
// - first multiframe carries an octet ramp counting up from 0 after /R/
// - second multiframe sends /Q/ second, then fourteen configuration octets
// - every other alignment slot carries ramp data
// - alignment octets are never scrambled
// - many configuration fields are coded as value minus one
// - after the fourth multiframe, user data frames follow
// - scrambled 0xfc at frame end becomes /F/
// - scrambled 0x7c at multiframe end becomes /A/
// - unscrambled repeat of last frame octet becomes /F/ or /A/
// - scrambling on after reset, software can disable it
// - alignment substitution on after reset, software can change it
// - control characters use the fixed 8-bit values
// - control code chosen from current running disparity
// - octets are 8b/10b encoded with dc balance
// - encoder bypass and output invert debug controls
// - sample format twos complement after reset, selectable
// - complex streams map I to first, Q to second virtual converter
// - up to four down-converters map onto at most eight converters
// - sync request low sends /K/; receiver releases after four good ones
// - self-synchronizing scrambler with polynomial 1 + x^14 + x^15
module jtl_tx_link #(
  parameter int F_OCTETS = 2,
  parameter int K_FRAMES = 32,
  parameter int NUM_DDC = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // link
  input wire logic sync_request_n,
  input wire logic lmfc_edge,
  // sample streams, one I/Q pair per clock per down-converter, one octet per clock per lane
  input wire jtl_pkg::jtl_iq_t ddc_in [NUM_DDC],
  input wire logic [7:0] lane_octet,
  // outputs
  output logic [15:0] vconv_out [2*NUM_DDC],
  output logic [9:0] lane_sym,
  output logic lane_is_k,
  output logic user_phase
);
  localparam int MF_LEN = F_OCTETS * K_FRAMES;

  // registers: 0 ctrl {lane_rate,twos,invert,bypass,align,scr}, 1 mode, 2..f cfg octets on write, f reads back link state
  logic scr_en_q, align_en_q, bypass_q, invert_q, twos_q, lane_rate_q;
  logic [2:0] mode_q;
  logic [7:0] cfg_q [`JTL_CFG_OCTETS];
  logic [1:0] st_q;
  jtl_pkg::jtl_state_t state_q, state_d;
  logic [9:0] slot_q;
  logic [2:0] mf_q;
  logic [7:0] ramp_q;
  logic [14:0] scr_q;
  logic rd_q;
  logic [7:0] prev_last_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scr_en_q <= `JTL_RST_SCR_EN;
      align_en_q <= `JTL_RST_ALIGN_EN;
      bypass_q <= 1'b0;
      invert_q <= 1'b0;
      twos_q <= `JTL_RST_TWOS;
      lane_rate_q <= 1'b0;
      mode_q <= 3'h7;
    end else if (reg_wr && reg_addr == 4'h0) begin
      {lane_rate_q, twos_q, invert_q, bypass_q, align_en_q, scr_en_q} <= reg_wdata[5:0];
    end else if (reg_wr && reg_addr == 4'h1) begin
      mode_q <= reg_wdata[2:0];
    end
  end

  // configuration octets, software writes value minus one where the field calls for it
  genvar gi;
  generate
    for (gi = 0; gi < `JTL_CFG_OCTETS; gi++) begin : g_cfg
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          cfg_q[gi] <= 8'h00;
        end else if (reg_wr && reg_addr == 4'(gi + 2)) begin
          cfg_q[gi] <= reg_wdata;
        end
      end
    end
  endgenerate

  wire [7:0] rd_mux = (reg_addr == 4'h0) ? {2'h0, lane_rate_q, twos_q, invert_q, bypass_q,
                      align_en_q, scr_en_q} :
                      (reg_addr == 4'h1) ? {4'h0, user_phase, mode_q} :
                      (reg_addr == 4'hf) ? {6'h0, st_q} : cfg_q[reg_addr - 4'h2];
  always_ff @(posedge clk) begin
    if (sys_rst) reg_rdata <= 8'h00;
    else if (reg_rd) reg_rdata <= rd_mux;
  end

  // link state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      jtl_pkg::JTL_CGS: if (sync_request_n) state_d = jtl_pkg::JTL_WAIT_LMFC;
      jtl_pkg::JTL_WAIT_LMFC: if (lmfc_edge) state_d = jtl_pkg::JTL_ILAS;
      jtl_pkg::JTL_ILAS: if (slot_q == 10'(MF_LEN - 1) && mf_q == `JTL_ILAS_MF - 3'h1)
        state_d = jtl_pkg::JTL_DATA;
      jtl_pkg::JTL_DATA: state_d = state_q;
    endcase
    if (!sync_request_n) state_d = jtl_pkg::JTL_CGS;
  end

  wire mf_end = slot_q == 10'(MF_LEN - 1);
  wire fr_end = (slot_q % 10'(F_OCTETS)) == 10'(F_OCTETS - 1);
  always_ff @(posedge clk) begin
    if (sys_rst || state_q != state_d) begin
      slot_q <= 10'h0;
      mf_q <= 3'h0;
      // starts one below zero so the octet after the opening /R/ reads 0
      ramp_q <= 8'hff;
    end else begin
      slot_q <= mf_end ? 10'h0 : slot_q + 10'h1;
      if (mf_end) mf_q <= mf_q + 3'h1;
      ramp_q <= ramp_q + 8'h01;
    end
    if (sys_rst) state_q <= jtl_pkg::JTL_CGS;
    else state_q <= state_d;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) st_q <= 2'h0;
    else st_q <= state_q;
  end

  // ilas octet, never scrambled
  wire cfg_slot = mf_q == 3'h1 && slot_q >= 10'(`JTL_CFG_START) &&
                  slot_q < 10'(`JTL_CFG_START) + 10'(`JTL_CFG_OCTETS);
  wire [3:0] cfg_idx = 4'(slot_q - 10'(`JTL_CFG_START));
  wire ilas_k = slot_q == 10'h0 || mf_end || (mf_q == 3'h1 && slot_q == 10'h1);
  wire [7:0] ilas_oct = slot_q == 10'h0 ? `JTL_K_R :
                        mf_end ? `JTL_K_A :
                        (mf_q == 3'h1 && slot_q == 10'h1) ? `JTL_K_Q :
                        cfg_slot ? cfg_q[cfg_idx] : ramp_q;

  // user data scrambler, self-synchronizing 1 + x^14 + x^15
  logic [7:0] scr_oct;
  logic [14:0] scr_nx;
  wire [7:0] data_in = twos_q ? lane_octet : {~lane_octet[7], lane_octet[6:0]};
  always_comb begin
    scr_nx = scr_q;
    for (int b = 7; b >= 0; b--) begin
      scr_oct[b] = data_in[b] ^ scr_nx[`JTL_SCR_TAP_HI] ^ scr_nx[`JTL_SCR_TAP_LO];
      scr_nx = {scr_nx[13:0], scr_oct[b]};
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) scr_q <= `JTL_SCR_SEED;
    else if (state_q == jtl_pkg::JTL_DATA && scr_en_q) scr_q <= scr_nx;
  end

  // alignment substitution
  wire [7:0] dat = scr_en_q ? scr_oct : data_in;
  wire sub_scr = scr_en_q && ((mf_end && dat == `JTL_K_A) ||
                 (fr_end && dat == `JTL_K_F));
  wire sub_raw = !scr_en_q && fr_end && dat == prev_last_q;
  wire sub = align_en_q && (sub_scr || sub_raw);
  wire [7:0] sub_oct = (mf_end && (sub_raw || dat == `JTL_K_A)) ? `JTL_K_A : `JTL_K_F;
  always_ff @(posedge clk) begin
    if (sys_rst) prev_last_q <= 8'h00;
    else if (state_q == jtl_pkg::JTL_DATA && fr_end) prev_last_q <= dat;
  end

  wire cur_k = (state_q == jtl_pkg::JTL_DATA) ? sub : (state_q == jtl_pkg::JTL_ILAS) ? ilas_k : 1'b1;
  wire [7:0] cur_oct = (state_q == jtl_pkg::JTL_DATA) ? (sub ? sub_oct : dat) :
                       (state_q == jtl_pkg::JTL_ILAS) ? ilas_oct : `JTL_K_K;

  // 8b/10b: 5b/6b and 3b/4b with running disparity
  function automatic logic [6:0] enc6(input logic [4:0] x);
    // returns {neutral, code at rd-}
    logic [5:0] c;
    c = 6'h00;
    unique case (x)
      5'd0: c = 6'b100111; 5'd1: c = 6'b011101; 5'd2: c = 6'b101101; 5'd3: c = 6'b110001;
      5'd4: c = 6'b110101; 5'd5: c = 6'b101001; 5'd6: c = 6'b011001; 5'd7: c = 6'b111000;
      5'd8: c = 6'b111001; 5'd9: c = 6'b100101; 5'd10: c = 6'b010101; 5'd11: c = 6'b110100;
      5'd12: c = 6'b001101; 5'd13: c = 6'b101100; 5'd14: c = 6'b011100; 5'd15: c = 6'b010111;
      5'd16: c = 6'b011011; 5'd17: c = 6'b100011; 5'd18: c = 6'b010011; 5'd19: c = 6'b110010;
      5'd20: c = 6'b001011; 5'd21: c = 6'b101010; 5'd22: c = 6'b011010; 5'd23: c = 6'b111010;
      5'd24: c = 6'b110011; 5'd25: c = 6'b100110; 5'd26: c = 6'b010110; 5'd27: c = 6'b110110;
      5'd28: c = 6'b001110; 5'd29: c = 6'b101110; 5'd30: c = 6'b011110; 5'd31: c = 6'b101011;
    endcase
    // d.07 keeps disparity too: both of its forms hold three ones
    return {($countones(c) == 3), c};
  endfunction
  function automatic logic [4:0] enc4(input logic [2:0] y);
    logic [3:0] c;
    c = 4'h0;
    unique case (y)
      3'd0: c = 4'b1011; 3'd1: c = 4'b1001; 3'd2: c = 4'b0101; 3'd3: c = 4'b1100;
      3'd4: c = 4'b1101; 3'd5: c = 4'b1010; 3'd6: c = 4'b0110; 3'd7: c = 4'b1110;
    endcase
    // x.3 keeps disparity too: both of its forms hold two ones
    return {($countones(c) == 2), c};
  endfunction

  logic [9:0] code;
  logic rd_nx;
  logic [6:0] e6;
  logic [4:0] e4;
  logic [5:0] s6;
  logic [3:0] s4;
  logic rd_mid;
  always_comb begin
    e6 = enc6(cur_oct[4:0]);
    e4 = enc4(cur_oct[7:5]);
    s6 = 6'h00;
    s4 = 4'h0;
    rd_mid = rd_q;
    if (cur_k) begin
      s6 = rd_q ? ~`JTL_K28_6B_NEG : `JTL_K28_6B_NEG;
      unique case (cur_oct[7:5])
        3'd0: s4 = `JTL_K28_R_4B_NEG;
        3'd3: s4 = `JTL_K28_A_4B_NEG;
        3'd4: s4 = `JTL_K28_Q_4B_NEG;
        3'd7: s4 = `JTL_K28_F_4B_NEG;
        default: s4 = `JTL_K28_K_4B_NEG;
      endcase
      if (rd_q) s4 = ~s4;
      // k28.3 and k28.5 are unbalanced and flip disparity, the rest keep it
      rd_nx = ($countones({s6, s4}) == 5) ? rd_q : ~rd_q;
    end else begin
      s6 = (!e6[6] && rd_q) ? ~e6[5:0] : e6[5:0];
      if (!e6[6]) rd_mid = ~rd_q;
      if (cur_oct[4:0] == 5'd7) s6 = rd_q ? 6'b000111 : 6'b111000;
      s4 = (!e4[4] && rd_mid) ? ~e4[3:0] : e4[3:0];
      if (cur_oct[7:5] == 3'd7 && ((!rd_mid && (cur_oct[4:0] == 5'd17 || cur_oct[4:0] == 5'd18 ||
          cur_oct[4:0] == 5'd20)) || (rd_mid && (cur_oct[4:0] == 5'd11 ||
          cur_oct[4:0] == 5'd13 || cur_oct[4:0] == 5'd14))))
        s4 = rd_mid ? 4'b1000 : 4'b0111;
      if (cur_oct[7:5] == 3'd3) s4 = rd_mid ? 4'b0011 : 4'b1100;
      rd_nx = e4[4] ? rd_mid : ~rd_mid;
    end
    code = {s6, s4};
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_q <= 1'b0;
      lane_sym <= 10'h000;
      lane_is_k <= 1'b0;
      user_phase <= 1'b0;
    end else begin
      rd_q <= rd_nx;
      // bypass passes the octet raw in the low bits; invert flips the line
      lane_sym <= (bypass_q ? {2'b00, cur_oct} : code) ^ {10{invert_q}};
      lane_is_k <= cur_k;
      user_phase <= state_q == jtl_pkg::JTL_DATA;
    end
  end

  // virtual converter mapping
  generate
    for (gi = 0; gi < 2 * NUM_DDC; gi++) begin : g_vc
      wire cplx = mode_q[2];
      wire [1:0] ndd = mode_q[1:0];
      wire [2:0] d_c = 3'(gi / 2);
      wire [2:0] d_r = 3'(gi);
      wire used = cplx ? (d_c <= {1'b0, ndd}) : (d_r <= {1'b0, ndd});
      always_ff @(posedge clk) begin
        if (sys_rst || !used) vconv_out[gi] <= 16'h0000;
        else if (cplx) vconv_out[gi] <= (gi % 2 == 0) ? ddc_in[gi/2].i : ddc_in[gi/2].q;
        else vconv_out[gi] <= ddc_in[gi % NUM_DDC].i;
      end
    end
  endgenerate

  ilas_entry_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == jtl_pkg::JTL_WAIT_LMFC && lmfc_edge && sync_request_n |=>
    state_q == jtl_pkg::JTL_ILAS) else $error("ilas not started at boundary");
  ilas_start_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == jtl_pkg::JTL_ILAS && slot_q == 10'h0 |-> cur_k && cur_oct == `JTL_K_R)
    else $error("multiframe lacks start char");
  ilas_q_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == jtl_pkg::JTL_ILAS && mf_q == 3'h1 && slot_q == 10'h1 |-> cur_oct == `JTL_K_Q)
    else $error("second char not Q");
  ilas_noscr_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == jtl_pkg::JTL_ILAS |=> $stable(scr_q)) else $error("scrambler ran in ilas");
  scr_sub_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == jtl_pkg::JTL_DATA && scr_en_q && align_en_q && fr_end && !mf_end &&
    dat == `JTL_K_F |-> cur_k) else $error("fc not replaced");
  cgs_k_a: assert property (@(posedge clk) disable iff (sys_rst)
    !sync_request_n |=> ##1 lane_is_k) else $error("no K during sync");
  disp_bal_a: assert property (@(posedge clk) disable iff (sys_rst)
    !sys_rst && !bypass_q && !invert_q |=> $countones(lane_sym) inside {4, 5, 6})
    else $error("unbalanced symbol");
  data_after_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == jtl_pkg::JTL_ILAS && mf_q == 3'h3 && mf_end && sync_request_n |=>
    state_q == jtl_pkg::JTL_DATA) else $error("no data after ilas");

  // named steps of link bring-up, shared by the properties below
  sequence s_boundary;
    state_q == jtl_pkg::JTL_WAIT_LMFC && lmfc_edge && sync_request_n;
  endsequence
  sequence s_ilas_open;
    state_q == jtl_pkg::JTL_ILAS && mf_q == 3'h0 && slot_q == 10'h0;
  endsequence
  sequence s_ilas_last;
    state_q == jtl_pkg::JTL_ILAS && mf_q == 3'h3 && mf_end && sync_request_n;
  endsequence
  sequence s_data_open;
    state_q == jtl_pkg::JTL_DATA && slot_q == 10'h0;
  endsequence

  // counters must restart on the boundary, or markers drift off the lmfc
  ilas_open_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_boundary |=> s_ilas_open) else $error("ilas opened off boundary");
  data_open_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_ilas_last |=> s_data_open ##1 user_phase) else $error("user phase not entered");
  ilas_end_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == jtl_pkg::JTL_ILAS && mf_end |-> cur_k && cur_oct == `JTL_K_A)
    else $error("multiframe lacks end char");
  ramp_run_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == jtl_pkg::JTL_ILAS && mf_q == 3'h0 && slot_q != 10'h0 && !mf_end |->
    !cur_k && cur_oct == 8'(slot_q - 10'h1)) else $error("ramp out of step");
  cfg_plain_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == jtl_pkg::JTL_ILAS && cfg_slot |-> !cur_k) else $error("config octet as K");
  a_sub_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == jtl_pkg::JTL_DATA && scr_en_q && align_en_q && mf_end && dat == `JTL_K_A |->
    cur_k && cur_oct == `JTL_K_A) else $error("7c not replaced");
  raw_sub_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == jtl_pkg::JTL_DATA && !scr_en_q && align_en_q && fr_end && dat == prev_last_q
    |-> cur_k && cur_oct == (mf_end ? `JTL_K_A : `JTL_K_F)) else $error("repeat not replaced");
  scr_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == jtl_pkg::JTL_DATA && !scr_en_q |=> $stable(scr_q))
    else $error("scrambler ran while off");
  k_flip_a: assert property (@(posedge clk) disable iff (sys_rst)
    !sys_rst && cur_k && cur_oct == `JTL_K_K |=> rd_q != $past(rd_q))
    else $error("sync char kept disparity");
  cgs_code_a: assert property (@(posedge clk) disable iff (sys_rst)
    !sys_rst && !bypass_q && !invert_q && cur_k && cur_oct == `JTL_K_K |=>
    lane_sym == 10'h0fa || lane_sym == 10'h305) else $error("bad sync code");
  iq_pair_a: assert property (@(posedge clk) disable iff (sys_rst)
    !sys_rst && mode_q == 3'h7 |=> vconv_out[1] == $past(ddc_in[0].q))
    else $error("q not on second converter");
  vc_unused_a: assert property (@(posedge clk) disable iff (sys_rst)
    !sys_rst && mode_q == 3'h0 |=> vconv_out[1] == 16'h0000)
    else $error("unused converter driven");
endmodule

// >>> testbench/jtl_rx_model.sv
`timescale 1ns/1ps
module jtl_rx_model #(
  parameter int HOLD = 30
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // bench control
  input wire logic resync,
  // lane from transmitter
  input wire logic [9:0] lane_sym,
  input wire logic lane_is_k,
  // sync request to transmitter
  output logic sync_request_n
);
  int good_q;
  int hold_q;
  logic is_sync_k;
  // raw octet form is accepted too, for the encoder bypass mode
  assign is_sync_k = lane_is_k && (lane_sym == 10'h0fa || lane_sym == 10'h305
                     || lane_sym == 10'h0bc);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_request_n <= 1'b1;
      good_q <= 0;
      hold_q <= 0;
    end else if (resync) begin
      sync_request_n <= 1'b0;
      good_q <= 0;
      hold_q <= 0;
    end else if (!sync_request_n) begin
      hold_q <= hold_q + 1;
      good_q <= is_sync_k ? good_q + 1 : 0;
      // hold stretches the request to act as a slow receiver
      if (good_q >= 4 && hold_q >= HOLD) begin
        sync_request_n <= 1'b1;
      end
    end
  end
endmodule

// >>> testbench/tb_jtl_tx_link.sv
`timescale 1ns/1ps
module tb_jtl_tx_link;
  localparam int FO = 2;
  localparam int KF = 16;
  localparam int MF = FO * KF;
  typedef struct packed {
    logic [3:0] wa;
    logic we;
    logic [7:0] wd;
    logic [3:0] ra;
    logic [7:0] exp;
  } jtl_row_t;
  logic clk, sys_rst, reg_wr, reg_rd, sync_request_n, lane_is_k, user_phase, resync;
  logic lmfc_edge = 1'b0;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, lane_octet, rv;
  logic [4:0] lcnt = 5'h00;
  jtl_pkg::jtl_iq_t ddc_in [4];
  logic [15:0] vconv_out [8];
  logic [9:0] lane_sym;
  logic [9:0] syms [4*MF];
  logic ks [4*MF];
  int n_errors, check_count, nk, na, w;
  jtl_row_t rows [7];
  jtl_tx_link #(.F_OCTETS(FO), .K_FRAMES(KF), .NUM_DDC(4)) dut_u (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sync_request_n(sync_request_n), .lmfc_edge(lmfc_edge),
    .ddc_in(ddc_in), .lane_octet(lane_octet), .vconv_out(vconv_out), .lane_sym(lane_sym),
    .lane_is_k(lane_is_k), .user_phase(user_phase));
  jtl_rx_model #(.HOLD(30)) rx_u (.clk(clk), .sys_rst(sys_rst), .resync(resync),
    .lane_sym(lane_sym), .lane_is_k(lane_is_k), .sync_request_n(sync_request_n));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // 5-bit wrap gives one multiframe of FO*KF = 32 clocks
  always @(posedge clk) begin
    lcnt <= lcnt + 5'h1;
    lmfc_edge <= (lcnt == 5'h1f);
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic give_up;
    n_errors++;
    complete_run();
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
    @(posedge clk);
  endtask
  task automatic grab(input int n);
    for (int i = 0; i < n; i++) begin
      syms[i] = lane_sym;
      ks[i] = lane_is_k;
      @(posedge clk);
      #1;
    end
  endtask
  task automatic pulse_resync;
    resync <= 1'b1;
    @(posedge clk);
    resync <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask
  initial begin
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    resync = 1'b0;
    lane_octet = 8'h55;
    for (int k = 0; k < 4; k++) ddc_in[k] = {16'h1000 + 16'(k), 16'h2000 + 16'(k)};
    rows[0] = '{4'h0, 1'b0, 8'h00, 4'h0, 8'h13};
    rows[1] = '{4'h0, 1'b0, 8'h00, 4'h1, 8'h07};
    rows[2] = '{4'h1, 1'b1, 8'h0f, 4'h1, 8'h07};
    rows[3] = '{4'he, 1'b1, 8'haa, 4'h0, 8'h13};
    rows[4] = '{4'h0, 1'b1, 8'h12, 4'h0, 8'h12};
    rows[5] = '{4'h0, 1'b1, 8'h13, 4'h0, 8'h13};
    rows[6] = '{4'h0, 1'b1, 8'h33, 4'h0, 8'h33};
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    foreach (rows[r]) begin
      if (rows[r].we) wr(rows[r].wa, rows[r].wd);
      rd(rows[r].ra);
      chk({8'h00, rv}, {8'h00, rows[r].exp});
    end
    wr(4'h1, 8'h01);
    repeat (2) @(posedge clk);
    #1;
    chk(vconv_out[0], ddc_in[0].i);
    chk(vconv_out[1], ddc_in[1].i);
    chk(vconv_out[2], 16'h0000);
    wr(4'h1, 8'h07);
    repeat (2) @(posedge clk);
    #1;
    for (int k = 0; k < 4; k++) begin
      chk(vconv_out[2*k], ddc_in[k].i);
      chk(vconv_out[2*k+1], ddc_in[k].q);
    end
    for (int c = 0; c < 14; c++) wr(4'(c + 2), 8'(8'h20 + c));
    pulse_resync();
    grab(6);
    for (int i = 0; i < 5; i++) begin
      chk(16'(ks[i]), 16'h1);
      chk(16'(syms[i] ^ syms[i+1]), 16'h3ff);
    end
    chk(16'(syms[0] == 10'h0fa || syms[0] == 10'h305), 16'h1);
    // bypass exposes raw octets; scrambler stays on to show alignment is plain
    wr(4'h0, 8'h17);
    w = 0;
    while (sync_request_n !== 1'b1 && w < 300) begin
      @(posedge clk);
      w++;
    end
    if (w >= 300) give_up();
    #1;
    w = 0;
    while (!(lane_is_k === 1'b1 && lane_sym === 10'h01c) && w < MF + 8) begin
      @(posedge clk);
      #1;
      w++;
    end
    if (w >= MF + 8) give_up();
    grab(4 * MF);
    for (int m = 0; m < 4; m++) begin
      chk(16'(syms[m*MF]), 16'h01c);
      chk(16'(syms[m*MF+MF-1]), 16'h07c);
    end
    for (int p = 1; p < MF - 1; p++) chk(16'(syms[p]), 16'(p - 1));
    chk(16'(syms[MF+1]), 16'h09c);
    for (int c = 0; c < 14; c++) chk(16'(syms[MF+2+c]), 16'(8'h20 + c));
    for (int p = 1; p < MF - 1; p++) chk(16'(ks[2*MF+p]), 16'h0);
    // constant data repeats every frame end, so each one is substituted with align on and none with align off
    for (int j = 0; j < 2; j++) begin
      wr(4'h0, j == 0 ? 8'h16 : 8'h14);
      repeat (MF) @(posedge clk);
      #1;
      chk(16'(user_phase), 16'h1);
      nk = 0;
      na = 0;
      for (int i = 0; i < 2 * MF; i++) begin
        if (lane_is_k === 1'b1) nk++;
        if (lane_is_k === 1'b1 && lane_sym === 10'h07c) na++;
        if (lane_is_k !== 1'b1) chk(16'(lane_sym), 16'h055);
        @(posedge clk);
        #1;
      end
      chk(16'(nk), j == 0 ? 16'(2 * KF) : 16'h0);
      chk(16'(na), j == 0 ? 16'h2 : 16'h0);
    end
    pulse_resync();
    chk(16'(lane_sym), 16'h0bc);
    chk(16'(user_phase), 16'h0);
    complete_run();
  end
endmodule
